/* File: hdl/asdir_pkg.sv */
// constants of the audio serial holding and event register block
package asdir_pkg;
    localparam int unsigned HALF_W = 16;
    localparam int unsigned WORD_W = 32;
    localparam int unsigned EVT_W = 6;
    localparam int unsigned SEL_W = 4;
    // register indices on the cpu select port
    localparam logic [3:0] IDX_TX_LEFT_LOW = 4'h0;
    localparam logic [3:0] IDX_TX_LEFT_HIGH = 4'h1;
    localparam logic [3:0] IDX_TX_RIGHT_LOW = 4'h2;
    localparam logic [3:0] IDX_TX_RIGHT_HIGH = 4'h3;
    localparam logic [3:0] IDX_EVENT_FLAGS = 4'h4;
    localparam logic [3:0] IDX_EVENT_MASK = 4'h5;
    localparam logic [3:0] IDX_RX_LEFT_LOW = 4'h6;
    localparam logic [3:0] IDX_RX_LEFT_HIGH = 4'h7;
    localparam logic [3:0] IDX_RX_RIGHT_LOW = 4'h8;
    localparam logic [3:0] IDX_RX_RIGHT_HIGH = 4'h9;
    // event flag and mask bit positions
    localparam int unsigned BIT_STEREO_TX = 5;
    localparam int unsigned BIT_SINGLE_TX = 4;
    localparam int unsigned BIT_STEREO_RX = 3;
    localparam int unsigned BIT_SINGLE_RX = 2;
    localparam int unsigned BIT_FRAMING = 1;
    localparam int unsigned BIT_OVER_UNDER = 0;
    // positions of the serializer event toggles
    localparam int unsigned EV_TX_LOAD = 0;
    localparam int unsigned EV_RX_DONE = 1;
    localparam int unsigned EV_FRAME_ERR = 2;
    localparam int unsigned EV_OVER_UNDER = 3;
    localparam int unsigned EV_COUNT = 4;
    // reset values and special masks
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [5:0] MASK_RESET = 6'h00;
    localparam logic [5:0] MASK_CLEAR_ON_READ = 6'h3C;
    localparam logic [31:0] DATA_RESET = 32'h0000_0000;
    localparam logic [15:0] READ_UNMAPPED = 16'h0000;
    localparam logic [9:0] RESERVED_ZERO = 10'h000;
endpackage : asdir_pkg

/* File: hdl/asdir_sync.sv */
// two-flop synchroniser with change detection on the synchronised side
`timescale 1ns/100ps
module asdir_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] level_out,
    output logic [WIDTH-1:0] change_out
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] last;

    // first stage feeds only the second one
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta <= '0;
            stable <= '0;
            last <= '0;
        end else begin
            meta <= async_in;
            stable <= meta;
            last <= stable;
        end
    end

    assign level_out = stable;
    assign change_out = stable ^ last;
endmodule : asdir_sync

/* File: hdl/asdir_regs.sv */
// holding registers, event flags and event mask of the audio serial port
`timescale 1ns/100ps
module asdir_regs (
    input wire logic CORE_CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic [3:0] CPU_SEL_IN,
    input wire logic CPU_WR_IN,
    input wire logic CPU_RD_IN,
    input wire logic [15:0] CPU_WDATA_IN,
    output logic [15:0] CPU_RDATA_OUT,
    output logic CPU_RVALID_OUT,
    input wire logic DMA_TX_WR_IN,
    input wire logic DMA_TX_SEL_IN,
    input wire logic [31:0] DMA_TX_DATA_IN,
    input wire logic DMA_RX_RD_IN,
    input wire logic DMA_RX_SEL_IN,
    output logic [31:0] DMA_RDATA_OUT,
    output logic DMA_RVALID_OUT,
    input wire logic MONO_IN,
    input wire logic TX_LOAD_TGL_IN,
    input wire logic RX_DONE_TGL_IN,
    input wire logic FRAME_ERR_TGL_IN,
    input wire logic OVER_UNDER_TGL_IN,
    input wire logic [31:0] RX_LEFT_IN,
    input wire logic [31:0] RX_RIGHT_IN,
    output logic [31:0] TX_LEFT_OUT,
    output logic [31:0] TX_RIGHT_OUT,
    output logic IRQ_OUT
);
    logic [3:0] ev;
    logic mono;
    logic ev_tx;
    logic ev_rx;
    logic ev_framing_error_irq_enable;
    logic ev_ovun;
    logic [31:0] tx_left;
    logic [31:0] tx_right;
    logic [31:0] rx_left;
    logic [31:0] rx_right;
    logic [5:0] event_flags;
    logic [5:0] event_enable_mask;
    logic [5:0] flag_set;
    logic tx_serviced;
    logic rx_serviced;
    logic underrun;
    logic overrun;
    logic cpu_tx_write;
    logic cpu_rx_read;
    logic flags_read;
    logic mask_read;
    logic mask_write;
    logic irq;
    logic [15:0] next_rdata;

    // serializer events arrive as toggles from the bit-clock side
    asdir_sync #(.WIDTH(asdir_pkg::EV_COUNT)) u_event_sync (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(RESET_N_IN),
        .async_in({OVER_UNDER_TGL_IN, FRAME_ERR_TGL_IN, RX_DONE_TGL_IN, TX_LOAD_TGL_IN}),
        .level_out(),
        .change_out(ev)
    );

    asdir_sync #(.WIDTH(1)) u_mode_sync (
        .clk_in(CORE_CLK_IN),
        .rst_n_in(RESET_N_IN),
        .async_in(MONO_IN),
        .level_out(mono),
        .change_out()
    );

    assign ev_tx = ev[asdir_pkg::EV_TX_LOAD];
    assign ev_rx = ev[asdir_pkg::EV_RX_DONE];
    assign ev_framing_error_irq_enable = ev[asdir_pkg::EV_FRAME_ERR];
    assign ev_ovun = ev[asdir_pkg::EV_OVER_UNDER];

    assign cpu_tx_write = CPU_WR_IN && (CPU_SEL_IN <= asdir_pkg::IDX_TX_RIGHT_HIGH);
    assign cpu_rx_read = CPU_RD_IN && (CPU_SEL_IN >= asdir_pkg::IDX_RX_LEFT_LOW)
        && (CPU_SEL_IN <= asdir_pkg::IDX_RX_RIGHT_HIGH);
    assign flags_read = CPU_RD_IN && (CPU_SEL_IN == asdir_pkg::IDX_EVENT_FLAGS);
    assign mask_read = CPU_RD_IN && (CPU_SEL_IN == asdir_pkg::IDX_EVENT_MASK);
    assign mask_write = CPU_WR_IN && (CPU_SEL_IN == asdir_pkg::IDX_EVENT_MASK);

    // cpu halves first, a dma word in the same cycle wins over the halves of its own word
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            tx_left <= asdir_pkg::DATA_RESET;
            tx_right <= asdir_pkg::DATA_RESET;
        end else begin
            if (CPU_WR_IN && CPU_SEL_IN == asdir_pkg::IDX_TX_LEFT_LOW) begin
                tx_left[15:0] <= CPU_WDATA_IN;
            end
            if (CPU_WR_IN && CPU_SEL_IN == asdir_pkg::IDX_TX_LEFT_HIGH) begin
                tx_left[31:16] <= CPU_WDATA_IN;
            end
            if (CPU_WR_IN && CPU_SEL_IN == asdir_pkg::IDX_TX_RIGHT_LOW) begin
                tx_right[15:0] <= CPU_WDATA_IN;
            end
            if (CPU_WR_IN && CPU_SEL_IN == asdir_pkg::IDX_TX_RIGHT_HIGH) begin
                tx_right[31:16] <= CPU_WDATA_IN;
            end
            if (DMA_TX_WR_IN && !DMA_TX_SEL_IN) begin
                tx_left <= DMA_TX_DATA_IN;
            end
            if (DMA_TX_WR_IN && DMA_TX_SEL_IN) begin
                tx_right <= DMA_TX_DATA_IN;
            end
        end
    end

    // the serializer holds its words stable for four core clocks after its toggle
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            rx_left <= asdir_pkg::DATA_RESET;
            rx_right <= asdir_pkg::DATA_RESET;
        end else if (ev_rx) begin
            rx_left <= RX_LEFT_IN;
            rx_right <= RX_RIGHT_IN;
        end
    end

    // servicing tracks whether software touched the buffers since the last swap;
    // an access in the swap cycle counts towards both the current and the next sample
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            tx_serviced <= 1'b1;
            rx_serviced <= 1'b1;
        end else begin
            tx_serviced <= (cpu_tx_write || DMA_TX_WR_IN) || (tx_serviced && !ev_tx);
            rx_serviced <= (cpu_rx_read || DMA_RX_RD_IN) || (rx_serviced && !ev_rx);
        end
    end

    assign underrun = ev_tx && !tx_serviced && !(cpu_tx_write || DMA_TX_WR_IN);
    assign overrun = ev_rx && !rx_serviced && !(cpu_rx_read || DMA_RX_RD_IN);

    always_comb begin
        flag_set = '0;
        flag_set[asdir_pkg::BIT_STEREO_TX] = ev_tx && !mono;
        flag_set[asdir_pkg::BIT_SINGLE_TX] = ev_tx && mono;
        flag_set[asdir_pkg::BIT_STEREO_RX] = ev_rx && !mono;
        flag_set[asdir_pkg::BIT_SINGLE_RX] = ev_rx && mono;
        flag_set[asdir_pkg::BIT_FRAMING] = ev_framing_error_irq_enable;
        flag_set[asdir_pkg::BIT_OVER_UNDER] = ev_ovun || underrun || overrun;
    end

    // a new event in the read cycle survives the clear
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            event_flags <= asdir_pkg::FLAGS_RESET;
        end else if (flags_read) begin
            event_flags <= flag_set;
        end else begin
            event_flags <= event_flags | flag_set;
        end
    end

    // a write in the same cycle as a read takes the written value
    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            event_enable_mask <= asdir_pkg::MASK_RESET;
        end else if (mask_write) begin
            event_enable_mask <= CPU_WDATA_IN[5:0];
        end else if (mask_read) begin
            event_enable_mask <= event_enable_mask & ~asdir_pkg::MASK_CLEAR_ON_READ;
        end
    end

    // transmit and receive flags only rise in their own mode, so mode gating is already folded in
    assign irq = |(event_flags & event_enable_mask);

    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            IRQ_OUT <= 1'b0;
        end else begin
            IRQ_OUT <= irq;
        end
    end

    always_comb begin
        next_rdata = asdir_pkg::READ_UNMAPPED;
        case (CPU_SEL_IN)
            asdir_pkg::IDX_TX_LEFT_LOW: next_rdata = tx_left[15:0];
            asdir_pkg::IDX_TX_LEFT_HIGH: next_rdata = tx_left[31:16];
            asdir_pkg::IDX_TX_RIGHT_LOW: next_rdata = tx_right[15:0];
            asdir_pkg::IDX_TX_RIGHT_HIGH: next_rdata = tx_right[31:16];
            asdir_pkg::IDX_EVENT_FLAGS: begin
                next_rdata = {asdir_pkg::RESERVED_ZERO, event_flags};
            end
            asdir_pkg::IDX_EVENT_MASK: begin
                next_rdata = {asdir_pkg::RESERVED_ZERO, event_enable_mask};
            end
            asdir_pkg::IDX_RX_LEFT_LOW: next_rdata = rx_left[15:0];
            asdir_pkg::IDX_RX_LEFT_HIGH: next_rdata = rx_left[31:16];
            asdir_pkg::IDX_RX_RIGHT_LOW: next_rdata = rx_right[15:0];
            asdir_pkg::IDX_RX_RIGHT_HIGH: next_rdata = rx_right[31:16];
            default: next_rdata = asdir_pkg::READ_UNMAPPED;
        endcase
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            CPU_RDATA_OUT <= asdir_pkg::READ_UNMAPPED;
            CPU_RVALID_OUT <= 1'b0;
        end else begin
            CPU_RVALID_OUT <= CPU_RD_IN;
            if (CPU_RD_IN) begin
                CPU_RDATA_OUT <= next_rdata;
            end
        end
    end

    always_ff @(posedge CORE_CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            DMA_RDATA_OUT <= asdir_pkg::DATA_RESET;
            DMA_RVALID_OUT <= 1'b0;
        end else begin
            DMA_RVALID_OUT <= DMA_RX_RD_IN;
            if (DMA_RX_RD_IN) begin
                DMA_RDATA_OUT <= DMA_RX_SEL_IN ? rx_right : rx_left;
            end
        end
    end

    assign TX_LEFT_OUT = tx_left;
    assign TX_RIGHT_OUT = tx_right;

    default clocking cb @(posedge CORE_CLK_IN);
    endclocking
    default disable iff (!RESET_N_IN);

    AST_TX_LEFT_LOW: assert property (
        (CPU_WR_IN && CPU_SEL_IN == asdir_pkg::IDX_TX_LEFT_LOW && !DMA_TX_WR_IN)
        |=> TX_LEFT_OUT[15:0] == $past(CPU_WDATA_IN) && $stable(TX_LEFT_OUT[31:16]))
        else $error("left low half not written");

    AST_TX_RIGHT_HIGH: assert property (
        (CPU_WR_IN && CPU_SEL_IN == asdir_pkg::IDX_TX_RIGHT_HIGH && !DMA_TX_WR_IN)
        |=> TX_RIGHT_OUT[31:16] == $past(CPU_WDATA_IN) && $stable(TX_RIGHT_OUT[15:0]))
        else $error("right high half not written");

    AST_DMA_WORD: assert property (
        DMA_TX_WR_IN |=> ($past(DMA_TX_SEL_IN) ? TX_RIGHT_OUT : TX_LEFT_OUT)
        == $past(DMA_TX_DATA_IN))
        else $error("dma word not taken whole");

    AST_RX_CAPTURE: assert property (
        $changed(RX_DONE_TGL_IN) |-> ##3 (rx_left == $past(RX_LEFT_IN)
        && rx_right == $past(RX_RIGHT_IN)))
        else $error("receive sample not captured");

    AST_RX_LEFT_LOW: assert property (
        (CPU_RD_IN && CPU_SEL_IN == asdir_pkg::IDX_RX_LEFT_LOW)
        |=> CPU_RVALID_OUT && CPU_RDATA_OUT == $past(rx_left[15:0]))
        else $error("left receive low half wrong");

    AST_STEREO_TX: assert property (
        (ev_tx && !mono) |=> event_flags[asdir_pkg::BIT_STEREO_TX])
        else $error("stereo transmit request missing");

    AST_MONO_TX: assert property (
        (ev_tx && mono) |=> event_flags[asdir_pkg::BIT_SINGLE_TX]
        && !$rose(event_flags[asdir_pkg::BIT_STEREO_TX]))
        else $error("mono transmit request missing");

    AST_STEREO_RX: assert property (
        (ev_rx && !mono) |=> event_flags[asdir_pkg::BIT_STEREO_RX])
        else $error("stereo receive flag missing");

    AST_MONO_RX: assert property (
        (ev_rx && mono) |=> event_flags[asdir_pkg::BIT_SINGLE_RX])
        else $error("mono receive flag missing");

    AST_FRAME_ERR: assert property (
        $changed(FRAME_ERR_TGL_IN) ##1 (!flags_read)[*3] |=> event_flags[asdir_pkg::BIT_FRAMING])
        else $error("frame error not flagged");

    AST_UNDERRUN: assert property (
        (ev_tx && !tx_serviced && !cpu_tx_write && !DMA_TX_WR_IN)
        |=> event_flags[asdir_pkg::BIT_OVER_UNDER])
        else $error("underrun not flagged");

    AST_FLAGS_CLEAR: assert property (
        (flags_read && flag_set == '0) |=> event_flags == '0 && CPU_RVALID_OUT)
        else $error("flags not cleared on read");

    AST_MASK_READ_CLEAR: assert property (
        (mask_read && !mask_write) |=> (event_enable_mask & asdir_pkg::MASK_CLEAR_ON_READ) == '0
        && event_enable_mask[1:0] == $past(event_enable_mask[1:0]))
        else $error("mask data bits survive a read");

    AST_IRQ_GATE: assert property (
        ##1 IRQ_OUT == $past(|(event_flags & event_enable_mask)))
        else $error("interrupt does not follow flags and mask");

    AST_RESERVED_ZERO: assert property (
        (CPU_RD_IN && (CPU_SEL_IN == asdir_pkg::IDX_EVENT_FLAGS
        || CPU_SEL_IN == asdir_pkg::IDX_EVENT_MASK)) |=> CPU_RDATA_OUT[15:6] == '0)
        else $error("reserved bits not zero");

    AST_TX_LEFT_HIGH: assert property (
        (CPU_WR_IN && CPU_SEL_IN == asdir_pkg::IDX_TX_LEFT_HIGH && !DMA_TX_WR_IN)
        |=> TX_LEFT_OUT[31:16] == $past(CPU_WDATA_IN) && $stable(TX_LEFT_OUT[15:0]))
        else $error("left high half not written");

    AST_TX_RIGHT_LOW: assert property (
        (CPU_WR_IN && CPU_SEL_IN == asdir_pkg::IDX_TX_RIGHT_LOW && !DMA_TX_WR_IN)
        |=> TX_RIGHT_OUT[15:0] == $past(CPU_WDATA_IN) && $stable(TX_RIGHT_OUT[31:16]))
        else $error("right low half not written");

    AST_DMA_RX_READ: assert property (
        DMA_RX_RD_IN |=> DMA_RVALID_OUT
        && DMA_RDATA_OUT == ($past(DMA_RX_SEL_IN) ? $past(rx_right) : $past(rx_left)))
        else $error("dma receive word wrong");

    AST_RX_READ_ONLY: assert property (
        (CPU_WR_IN && CPU_SEL_IN >= asdir_pkg::IDX_RX_LEFT_LOW && !ev_rx)
        |=> $stable(rx_left) && $stable(rx_right))
        else $error("receive holding register written by cpu");

    AST_OVERRUN: assert property (
        (ev_rx && !rx_serviced && !cpu_rx_read && !DMA_RX_RD_IN)
        |=> event_flags[asdir_pkg::BIT_OVER_UNDER])
        else $error("overrun not flagged");

    AST_FLAGS_STICK: assert property (
        !flags_read |=> (event_flags & $past(event_flags)) == $past(event_flags))
        else $error("event flag dropped without a read");

    AST_MASK_WRITE: assert property (
        mask_write |=> event_enable_mask == $past(CPU_WDATA_IN[5:0]))
        else $error("mask write not taken");

    AST_IRQ_MASKED: assert property (
        (event_flags & event_enable_mask) == '0 |=> !IRQ_OUT)
        else $error("interrupt raised while masked");

    AST_CPU_RVALID: assert property (
        !CPU_RD_IN |=> !CPU_RVALID_OUT)
        else $error("read answer without a read");

    COV_STEREO_IRQ: cover property (ev_tx && !mono ##[1:3] IRQ_OUT);
    COV_MONO_RX: cover property (ev_rx && mono ##[1:20] flags_read);
    COV_OVERRUN: cover property (overrun);
    COV_MASK_CLEAR: cover property (mask_read && event_enable_mask[asdir_pkg::BIT_STEREO_TX]);
    COV_UNDERRUN: cover property (underrun);
endmodule : asdir_regs

/* File: verification/asdir_serial_model.sv */
// behavioural model of the serializer side: event toggles and received samples
`timescale 1ns/100ps
module asdir_serial_model (
    output logic tx_load_tgl_out,
    output logic rx_done_tgl_out,
    output logic frame_err_tgl_out,
    output logic over_under_tgl_out,
    output logic [31:0] rx_left_out,
    output logic [31:0] rx_right_out
);
    logic link_clk;
    initial begin
        link_clk = 1'b0;
        tx_load_tgl_out = 1'b0;
        rx_done_tgl_out = 1'b0;
        frame_err_tgl_out = 1'b0;
        over_under_tgl_out = 1'b0;
        rx_left_out = 32'h0000_0000;
        rx_right_out = 32'h0000_0000;
    end
    // link clock runs only while a frame is in flight, 400 ns period
    task automatic frame(input logic [3:0] ev, input logic [31:0] l, input logic [31:0] r);
        #200 link_clk = 1'b1;
        tx_load_tgl_out = tx_load_tgl_out ^ ev[asdir_pkg::EV_TX_LOAD];
        frame_err_tgl_out = frame_err_tgl_out ^ ev[asdir_pkg::EV_FRAME_ERR];
        over_under_tgl_out = over_under_tgl_out ^ ev[asdir_pkg::EV_OVER_UNDER];
        if (ev[asdir_pkg::EV_RX_DONE]) begin
            rx_left_out = l;
            rx_right_out = r;
            rx_done_tgl_out = ~rx_done_tgl_out;
        end
        #200 link_clk = 1'b0;
        // samples go stale after the four-clock hold so a late capture shows up
        if (ev[asdir_pkg::EV_RX_DONE]) begin
            rx_left_out = ~l;
            rx_right_out = ~r;
        end
        #400;
    endtask : frame
endmodule : asdir_serial_model

/* File: verification/tb.sv */
// self-checking bench of the holding, flag and mask registers
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb;
    logic clk, rst_n, cpu_wr, cpu_rd, dma_wr, dma_tx_sel, dma_rd, dma_rx_sel, mono;
    logic rvalid, dma_rvalid, irq, t_load, t_rx, t_framing_error_irq_enable, t_ou;
    logic [3:0] sel;
    logic [15:0] wdata, rdata;
    logic [31:0] dma_wdata, dma_rdata, tx_left, tx_right, rx_left, rx_right;
    int err_count = 0;
    int checks = 0;
    asdir_regs dut (.CORE_CLK_IN(clk), .RESET_N_IN(rst_n), .CPU_SEL_IN(sel),
        .CPU_WR_IN(cpu_wr), .CPU_RD_IN(cpu_rd), .CPU_WDATA_IN(wdata),
        .CPU_RDATA_OUT(rdata), .CPU_RVALID_OUT(rvalid), .DMA_TX_WR_IN(dma_wr),
        .DMA_TX_SEL_IN(dma_tx_sel), .DMA_TX_DATA_IN(dma_wdata), .DMA_RX_RD_IN(dma_rd),
        .DMA_RX_SEL_IN(dma_rx_sel), .DMA_RDATA_OUT(dma_rdata), .DMA_RVALID_OUT(dma_rvalid),
        .MONO_IN(mono), .TX_LOAD_TGL_IN(t_load), .RX_DONE_TGL_IN(t_rx),
        .FRAME_ERR_TGL_IN(t_framing_error_irq_enable), .OVER_UNDER_TGL_IN(t_ou), .RX_LEFT_IN(rx_left),
        .RX_RIGHT_IN(rx_right), .TX_LEFT_OUT(tx_left), .TX_RIGHT_OUT(tx_right),
        .IRQ_OUT(irq));
    asdir_serial_model serial (.tx_load_tgl_out(t_load), .rx_done_tgl_out(t_rx),
        .frame_err_tgl_out(t_framing_error_irq_enable), .over_under_tgl_out(t_ou),
        .rx_left_out(rx_left), .rx_right_out(rx_right));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task automatic complete_run;
        $display("checks %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : complete_run
    task automatic cpu_write(input logic [3:0] s, input logic [15:0] d);
        @(negedge clk);
        sel = s;
        wdata = d;
        cpu_wr = 1'b1;
        @(negedge clk);
        cpu_wr = 1'b0;
    endtask : cpu_write
    // answer stands for exactly one cycle, so it is sampled at the next falling edge
    task automatic cpu_read(input logic [3:0] s, input logic [15:0] exp);
        @(negedge clk);
        sel = s;
        cpu_rd = 1'b1;
        @(negedge clk);
        cpu_rd = 1'b0;
        `CHK(rvalid, 1'b1)
        `CHK(rdata, exp)
    endtask : cpu_read
    task automatic dma_write(input logic s, input logic [31:0] d);
        @(negedge clk);
        dma_tx_sel = s;
        dma_wdata = d;
        dma_wr = 1'b1;
        @(negedge clk);
        dma_wr = 1'b0;
    endtask : dma_write
    task automatic dma_read(input logic s, input logic [31:0] exp);
        @(negedge clk);
        dma_rx_sel = s;
        dma_rd = 1'b1;
        @(negedge clk);
        dma_rd = 1'b0;
        `CHK(dma_rvalid, 1'b1)
        `CHK(dma_rdata, exp)
    endtask : dma_read
    task automatic set_mode(input logic m);
        mono = m;
        // mode passes a two-flop synchroniser before it steers the flags
        repeat (4) @(negedge clk);
    endtask : set_mode
    initial begin
        #2_000_000;
        err_count++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0;
        {cpu_wr, cpu_rd, dma_wr, dma_tx_sel, dma_rd, dma_rx_sel, mono} = 7'h00;
        sel = 4'h0;
        wdata = 16'h0000;
        dma_wdata = 32'h0000_0000;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        `CHK(tx_left, 32'h0000_0000)
        `CHK(irq, 1'b0)
        cpu_read(asdir_pkg::IDX_EVENT_FLAGS, 16'h0000);
        cpu_read(asdir_pkg::IDX_EVENT_MASK, 16'h0000);
        cpu_write(asdir_pkg::IDX_TX_LEFT_LOW, 16'h1357);
        cpu_write(asdir_pkg::IDX_TX_LEFT_HIGH, 16'h2468);
        cpu_write(asdir_pkg::IDX_TX_RIGHT_LOW, 16'hA5C3);
        cpu_write(asdir_pkg::IDX_TX_RIGHT_HIGH, 16'h5A3C);
        `CHK(tx_left, 32'h2468_1357)
        `CHK(tx_right, 32'h5A3C_A5C3)
        cpu_read(asdir_pkg::IDX_TX_RIGHT_HIGH, 16'h5A3C);
        cpu_read(4'hF, 16'h0000);
        dma_write(1'b1, 32'hCAFE_0001);
        `CHK(tx_right, 32'hCAFE_0001)
        dma_write(1'b0, 32'h0BAD_F00D);
        cpu_read(asdir_pkg::IDX_TX_LEFT_LOW, 16'hF00D);
        cpu_read(asdir_pkg::IDX_TX_LEFT_HIGH, 16'h0BAD);
        cpu_write(asdir_pkg::IDX_EVENT_FLAGS, 16'h003F);
        cpu_write(asdir_pkg::IDX_EVENT_MASK, 16'hFFFF);
        cpu_read(asdir_pkg::IDX_EVENT_MASK, 16'h003F);
        cpu_read(asdir_pkg::IDX_EVENT_MASK, 16'h0003);
        cpu_write(asdir_pkg::IDX_EVENT_MASK, 16'h0020);
        serial.frame(4'h1, 32'h0, 32'h0);
        `CHK(irq, 1'b1)
        cpu_read(asdir_pkg::IDX_EVENT_FLAGS, 16'h0020);
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b0)
        set_mode(1'b1);
        cpu_write(asdir_pkg::IDX_EVENT_MASK, 16'h0010);
        serial.frame(4'h1, 32'h0, 32'h0);
        `CHK(irq, 1'b1)
        cpu_read(asdir_pkg::IDX_EVENT_FLAGS, 16'h0011);
        cpu_write(asdir_pkg::IDX_EVENT_MASK, 16'h0000);
        serial.frame(4'h4, 32'h0, 32'h0);
        `CHK(irq, 1'b0)
        cpu_write(asdir_pkg::IDX_EVENT_MASK, 16'h0002);
        repeat (2) @(negedge clk);
        `CHK(irq, 1'b1)
        cpu_read(asdir_pkg::IDX_EVENT_FLAGS, 16'h0002);
        set_mode(1'b0);
        cpu_write(asdir_pkg::IDX_EVENT_MASK, 16'h0008);
        serial.frame(4'h2, 32'h89AB_CDEF, 32'h1234_5678);
        `CHK(irq, 1'b1)
        cpu_read(asdir_pkg::IDX_EVENT_FLAGS, 16'h0008);
        cpu_read(asdir_pkg::IDX_RX_LEFT_LOW, 16'hCDEF);
        cpu_read(asdir_pkg::IDX_RX_LEFT_HIGH, 16'h89AB);
        dma_read(1'b1, 32'h1234_5678);
        set_mode(1'b1);
        cpu_write(asdir_pkg::IDX_EVENT_MASK, 16'h0004);
        serial.frame(4'h2, 32'h0F0F_1111, 32'h0);
        serial.frame(4'h2, 32'h7E7E_2222, 32'h0);
        `CHK(irq, 1'b1)
        cpu_read(asdir_pkg::IDX_EVENT_FLAGS, 16'h0005);
        dma_read(1'b0, 32'h7E7E_2222);
        cpu_write(asdir_pkg::IDX_RX_LEFT_LOW, 16'h0000);
        cpu_read(asdir_pkg::IDX_RX_LEFT_LOW, 16'h2222);
        cpu_write(asdir_pkg::IDX_EVENT_MASK, 16'h0001);
        serial.frame(4'h8, 32'h0, 32'h0);
        `CHK(irq, 1'b1)
        cpu_read(asdir_pkg::IDX_EVENT_FLAGS, 16'h0001);
        complete_run();
    end
endmodule : tb
